// ---- hdl/irq_control.sv ----
// Interrupt control: external line flags, masks, ranking, entry and sleep.
// Assumes a CPU core on mclk that offers instruction boundaries, the
// status global enable and its program counter, and timers that hold flags.
//
// Contract
// - Reset pin low over 50 ns resets.
// - Port pins float while any reset.
// - Power-down stops all until external wake.
// - Idle halts CPU only; interrupts still run.
// - Global enable gates every interrupt.
// - Each source jumps to its own vector.
// - Lowest vector address wins when several pending.
// - Entry pushes return program counter.
// - Line b edge sets its flag bit 7.
// - Line a edge sets its flag bit 6.
// - Entering routine clears its line flag.
// - Writing one clears flag; zero keeps.
// - Level sensing holds flag cleared.
// - Level request pends only while low.
// - Flag register low six bits read zero.
// - Timer 1 overflow takes vector 5.
// - Timer 1 compare takes vector 4.
// - Sense select: low, reserved, fall, rise.
// - Pins sampled before edge detection.
`timescale 1ns/1ps
module irq_control (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic ext_irq_line_a,
    input wire logic ext_irq_line_b,
    input wire irq_ctrl_pkg::io_req_t io_req,
    input wire logic global_irq_enable,
    input wire logic cpu_boundary,
    input wire logic [9:0] program_counter,
    input wire irq_ctrl_pkg::timer_flags_t timer_flags,
    input wire logic sleep_cmd,
    output logic [7:0] io_rdata,
    output logic irq_enter,
    output irq_ctrl_pkg::irq_entry_t irq_entry,
    output irq_ctrl_pkg::timer_flags_t timer_ack,
    output logic cpu_halt,
    output logic osc_stop,
    output logic port_tristate,
    output logic sys_reset
);
    // ==========================================================
    // Declarations
    logic pin_reset; // Filtered reset pin
    logic sys_rst; // Any reset condition
    logic [7:0] timer_mask_reg; // Timer interrupt enables
    logic [7:0] general_irq_mask_reg; // External line enables
    logic [7:0] sense_ctrl_reg; // Sense selects and sleep mode
    logic ext_line0_flag_reg; // Line a edge flag
    logic ext_line1_flag_reg; // Line b edge flag
    logic ext_line0_flag_next;
    logic ext_line1_flag_next;
    logic [1:0] line_a_sense_sel; // Line a request condition
    logic [1:0] line_b_sense_sel; // Line b request condition
    logic edge_a; // Line a edge event
    logic edge_b; // Line b edge event
    logic level_a; // Line a low-level request
    logic level_b; // Line b low-level request
    logic wr_flags; // Write to the flag register
    logic [5:0] pend; // Enabled pending sources, by vector rank
    logic [5:0] grant; // Lowest-ranked pending source
    logic [9:0] grant_vec; // Vector of the granted source
    logic take_now; // Interrupt taken this cycle
    logic wake_ext; // External wake from power-down
    // One-hot sleep state and its next value
    irq_ctrl_pkg::sleep_state_t state_reg; // Sleep state
    irq_ctrl_pkg::sleep_state_t state_next;

    assign sys_rst = rst | pin_reset;
    assign line_a_sense_sel = sense_ctrl_reg[irq_ctrl_pkg::LINE_A_SENSE_LSB +: 2];
    assign line_b_sense_sel = sense_ctrl_reg[irq_ctrl_pkg::LINE_B_SENSE_LSB +: 2];
    assign wr_flags = io_req.wr && (io_req.addr == irq_ctrl_pkg::EXT_FLAG_ADDR);

    // ==========================================================
    // Reset pin filter
    reset_pin_filter u_rst_filter (
        .mclk(mclk),
        .rst(rst),
        .reset_pin_n(reset_pin_n),
        .pin_reset(pin_reset)
    );

    // ==========================================================
    // External line samplers
    ext_line_sense u_sense_a (
        .mclk(mclk),
        .rst(sys_rst),
        .pin(ext_irq_line_a),
        .sense_sel(line_a_sense_sel),
        .edge_event(edge_a),
        .level_req(level_a)
    );

    ext_line_sense u_sense_b (
        .mclk(mclk),
        .rst(sys_rst),
        .pin(ext_irq_line_b),
        .sense_sel(line_b_sense_sel),
        .edge_event(edge_b),
        .level_req(level_b)
    );

    // ==========================================================
    // Reset outputs
    always_ff @(posedge mclk) begin
        // Pins float and the chip is held whenever a reset is active
        port_tristate <= sys_rst;
        sys_reset <= sys_rst;
    end

    // ==========================================================
    // Writable control registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            timer_mask_reg <= irq_ctrl_pkg::TIMER_MASK_RST;
            general_irq_mask_reg <= irq_ctrl_pkg::GEN_MASK_RST;
            sense_ctrl_reg <= irq_ctrl_pkg::SENSE_CTRL_RST;
        end else if (io_req.wr) begin
            // Only writable bits take the data
            if (io_req.addr == irq_ctrl_pkg::TIMER_MASK_ADDR) begin
                timer_mask_reg <= io_req.wdata & irq_ctrl_pkg::TIMER_MASK_RW;
            end
            if (io_req.addr == irq_ctrl_pkg::GEN_MASK_ADDR) begin
                general_irq_mask_reg <= io_req.wdata & irq_ctrl_pkg::GEN_MASK_RW;
            end
            if (io_req.addr == irq_ctrl_pkg::SENSE_CTRL_ADDR) begin
                sense_ctrl_reg <= io_req.wdata & irq_ctrl_pkg::SENSE_CTRL_RW;
            end
        end
    end

    // ==========================================================
    // External flag next values: set wins over any clear
    always_comb begin
        ext_line0_flag_next = ext_line0_flag_reg;
        ext_line1_flag_next = ext_line1_flag_reg;
        // Hardware clear on entry
        if (take_now && grant[0]) begin
            ext_line0_flag_next = 1'b0;
        end
        if (take_now && grant[1]) begin
            ext_line1_flag_next = 1'b0;
        end
        // Write-one clear, zero keeps
        if (wr_flags && io_req.wdata[irq_ctrl_pkg::EXT0_BIT]) begin
            ext_line0_flag_next = 1'b0;
        end
        if (wr_flags && io_req.wdata[irq_ctrl_pkg::EXT1_BIT]) begin
            ext_line1_flag_next = 1'b0;
        end
        // Edge events set after the entry and write clears so they win
        if (edge_a) begin
            ext_line0_flag_next = 1'b1;
        end
        if (edge_b) begin
            ext_line1_flag_next = 1'b1;
        end
        // Level sensing keeps the flag cleared
        if (line_a_sense_sel == irq_ctrl_pkg::SENSE_LOW) begin
            ext_line0_flag_next = 1'b0;
        end
        if (line_b_sense_sel == irq_ctrl_pkg::SENSE_LOW) begin
            ext_line1_flag_next = 1'b0;
        end
    end

    // ==========================================================
    // External flag registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ext_line0_flag_reg <= 1'b0;
            ext_line1_flag_reg <= 1'b0;
        end else begin
            ext_line0_flag_reg <= ext_line0_flag_next;
            ext_line1_flag_reg <= ext_line1_flag_next;
        end
    end

    // ==========================================================
    // Register read port, data from a flop the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            io_rdata <= irq_ctrl_pkg::RDATA_RST;
        end else if (io_req.rd) begin
            unique case (io_req.addr)
                irq_ctrl_pkg::TIMER_MASK_ADDR: io_rdata <= timer_mask_reg;
                irq_ctrl_pkg::GEN_MASK_ADDR: io_rdata <= general_irq_mask_reg;
                irq_ctrl_pkg::SENSE_CTRL_ADDR: io_rdata <= sense_ctrl_reg;
                // Low six bits read as zero
                irq_ctrl_pkg::EXT_FLAG_ADDR: io_rdata <= {ext_line1_flag_reg,
                                                         ext_line0_flag_reg,
                                                         6'h00};
                default: io_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Pending sources in vector order; level requests are not latched
    always_comb begin
        pend[0] = general_irq_mask_reg[irq_ctrl_pkg::EXT0_BIT]
                  & (ext_line0_flag_reg | level_a);
        pend[1] = general_irq_mask_reg[irq_ctrl_pkg::EXT1_BIT]
                  & (ext_line1_flag_reg | level_b);
        pend[2] = timer_mask_reg[irq_ctrl_pkg::T1_CAPT_BIT] & timer_flags.t1_capt;
        pend[3] = timer_mask_reg[irq_ctrl_pkg::T1_COMP_BIT] & timer_flags.t1_comp;
        pend[4] = timer_mask_reg[irq_ctrl_pkg::T1_OVF_BIT] & timer_flags.t1_ovf;
        pend[5] = timer_mask_reg[irq_ctrl_pkg::T0_OVF_BIT] & timer_flags.t0_ovf;
    end

    // ==========================================================
    // Ranking: the lowest vector address wins
    always_comb begin
        grant = pend & (~pend + 6'h01);
        grant_vec = 10'h000;
        for (int i = 0; i < 6; i++) begin
            if (grant[i]) begin
                grant_vec = irq_ctrl_pkg::VEC_TABLE[i];
            end
        end
    end

    // Take only with global enable, at a boundary or from idle
    assign take_now = global_irq_enable && (pend != 6'h00) && !irq_enter
                      && ((state_reg == irq_ctrl_pkg::ST_RUN && cpu_boundary)
                          || state_reg == irq_ctrl_pkg::ST_IDLE);

    // Enabled external conditions wake from power-down
    assign wake_ext = (general_irq_mask_reg[irq_ctrl_pkg::EXT0_BIT] & (edge_a | level_a))
                      | (general_irq_mask_reg[irq_ctrl_pkg::EXT1_BIT] & (edge_b | level_b));

    // ==========================================================
    // Interrupt entry: vector, return address and timer acks
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_enter <= 1'b0;
            irq_entry <= '0;
            timer_ack <= '0;
        end else begin
            irq_enter <= take_now;
            timer_ack.t1_capt <= take_now & grant[2];
            timer_ack.t1_comp <= take_now & grant[3];
            timer_ack.t1_ovf <= take_now & grant[4];
            timer_ack.t0_ovf <= take_now & grant[5];
            if (take_now) begin
                irq_entry.vector <= grant_vec;
                irq_entry.ret_pc <= program_counter;
            end
        end
    end

    // ==========================================================
    // Sleep state machine
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            irq_ctrl_pkg::ST_RUN: begin
                if (sleep_cmd) begin
                    state_next = sense_ctrl_reg[irq_ctrl_pkg::SLEEP_MODE_BIT]
                                 ? irq_ctrl_pkg::ST_PDOWN : irq_ctrl_pkg::ST_IDLE;
                end
            end
            irq_ctrl_pkg::ST_IDLE: begin
                // Interrupt logic keeps running; a taken request wakes the CPU
                if (take_now) begin
                    state_next = irq_ctrl_pkg::ST_RUN;
                end
            end
            irq_ctrl_pkg::ST_PDOWN: begin
                // Only an external interrupt or reset ends power-down
                if (wake_ext) begin
                    state_next = irq_ctrl_pkg::ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= irq_ctrl_pkg::ST_RUN;
            cpu_halt <= 1'b0;
            osc_stop <= 1'b0;
        end else begin
            state_reg <= state_next;
            cpu_halt <= (state_next != irq_ctrl_pkg::ST_RUN);
            osc_stop <= (state_next == irq_ctrl_pkg::ST_PDOWN);
        end
    end

    // ==========================================================
    // Assertions
    tristate_on_reset_a: assert property (@(posedge mclk) disable iff (rst)
        pin_reset |=> port_tristate) else $error("port pins not floated in reset");

    gie_gates_entry_a: assert property (@(posedge mclk) disable iff (sys_rst)
        irq_enter |-> $past(global_irq_enable))
        else $error("entry without global enable");

    lowest_wins_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(irq_enter) && $past(pend[0]) |-> irq_entry.vector == irq_ctrl_pkg::VEC_EXT_A)
        else $error("lowest vector not taken first");

    ovf1_vector_a: assert property (@(posedge mclk) disable iff (sys_rst)
        take_now && pend == 6'h10 |=> irq_enter && irq_entry.vector == 10'h005)
        else $error("timer 1 overflow wrong vector");

    ret_pc_push_a: assert property (@(posedge mclk) disable iff (sys_rst)
        take_now |=> irq_entry.ret_pc == $past(program_counter))
        else $error("return address not pushed");

    hw_clear_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
        take_now && grant[0] && !edge_a |=> !ext_line0_flag_reg)
        else $error("line a flag not cleared on entry");

    w1c_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_flags && io_req.wdata[7] && !edge_b |=> !ext_line1_flag_reg)
        else $error("line b flag not cleared by write");

    set_wins_a: assert property (@(posedge mclk) disable iff (sys_rst)
        edge_a |=> ext_line0_flag_reg)
        else $error("line a edge lost");

    level_no_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
        line_b_sense_sel == irq_ctrl_pkg::SENSE_LOW |=> !ext_line1_flag_reg)
        else $error("level mode flag set");

    flag_low_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
        io_req.rd && io_req.addr == irq_ctrl_pkg::EXT_FLAG_ADDR |=> io_rdata[5:0] == 6'h00)
        else $error("reserved flag bits not zero");

    timer_mask_rsvd_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (timer_mask_reg & ~irq_ctrl_pkg::TIMER_MASK_RW) == 8'h00)
        else $error("timer mask reserved bit set");

    pdown_entry_a: assert property (@(posedge mclk) disable iff (sys_rst)
        state_reg == irq_ctrl_pkg::ST_RUN && sleep_cmd && sense_ctrl_reg[4]
        |=> osc_stop && cpu_halt) else $error("power-down not entered");

    idle_entry_a: assert property (@(posedge mclk) disable iff (sys_rst)
        state_reg == irq_ctrl_pkg::ST_RUN && sleep_cmd && !sense_ctrl_reg[4]
        |=> cpu_halt && !osc_stop) else $error("idle stopped the oscillator");
endmodule

// ---- hdl/irq_ctrl_pkg.sv ----
// Shared constants and types for the interrupt control block.
// Assumes an 8-bit I/O space with 6-bit addresses and a 10-bit program counter.
package irq_ctrl_pkg;

    // ==========================================================
    // I/O space offsets
    localparam logic [5:0] TIMER_MASK_ADDR = 6'h39; // Timer interrupt mask
    localparam logic [5:0] EXT_FLAG_ADDR = 6'h3A; // External line flags
    localparam logic [5:0] GEN_MASK_ADDR = 6'h3B; // External line enables
    localparam logic [5:0] SENSE_CTRL_ADDR = 6'h35; // Sense select and sleep mode

    // ==========================================================
    // Field positions
    localparam int EXT1_BIT = 7; // Line b flag and enable
    localparam int EXT0_BIT = 6; // Line a flag and enable
    localparam int T1_OVF_BIT = 7; // Timer 1 overflow enable
    localparam int T1_COMP_BIT = 6; // Timer 1 compare enable
    localparam int T1_CAPT_BIT = 3; // Timer 1 capture enable
    localparam int T0_OVF_BIT = 1; // Timer 0 overflow enable
    localparam int SLEEP_MODE_BIT = 4; // One selects power-down
    localparam int LINE_B_SENSE_LSB = 2; // Line b sense select
    localparam int LINE_A_SENSE_LSB = 0; // Line a sense select

    // Writable bit masks
    localparam logic [7:0] TIMER_MASK_RW = 8'hCA;
    localparam logic [7:0] GEN_MASK_RW = 8'hC0;
    localparam logic [7:0] SENSE_CTRL_RW = 8'h1F;
    localparam logic [7:0] EXT_FLAG_RW = 8'hC0;

    // Values after reset
    localparam logic [7:0] TIMER_MASK_RST = 8'h00;
    localparam logic [7:0] GEN_MASK_RST = 8'h00;
    localparam logic [7:0] SENSE_CTRL_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // ==========================================================
    // Sense select codes
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_RSVD = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;

    // ==========================================================
    // Vector table, index 0 has the lowest address and ranks first
    localparam logic [9:0] VEC_EXT_A = 10'h001;
    localparam logic [9:0] VEC_EXT_B = 10'h002;
    localparam logic [9:0] VEC_T1_CAPT = 10'h003;
    localparam logic [9:0] VEC_T1_COMP = 10'h004;
    localparam logic [9:0] VEC_T1_OVF = 10'h005;
    localparam logic [9:0] VEC_T0_OVF = 10'h006;
    localparam logic [5:0][9:0] VEC_TABLE = {VEC_T0_OVF, VEC_T1_OVF, VEC_T1_COMP,
                                             VEC_T1_CAPT, VEC_EXT_B, VEC_EXT_A};

    // ==========================================================
    // Reset pin timing
    localparam int RST_MIN_NS = 50; // Least low time that resets
    localparam int MCLK_PERIOD_NS = 25; // 40 MHz system clock
    localparam logic [2:0] RST_MIN_CYC =
        3'((RST_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);

    // ==========================================================
    // Types
    typedef struct packed {
        logic [5:0] addr; // I/O address
        logic wr; // Write strobe
        logic rd; // Read strobe
        logic [7:0] wdata; // Write data
    } io_req_t;

    typedef struct packed {
        logic t1_ovf; // Timer 1 overflow
        logic t1_comp; // Timer 1 compare match
        logic t1_capt; // Timer 1 capture
        logic t0_ovf; // Timer 0 overflow
    } timer_flags_t;

    typedef struct packed {
        logic [9:0] vector; // Word address to jump to
        logic [9:0] ret_pc; // Return address to push
    } irq_entry_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_IDLE = 3'b010,
        ST_PDOWN = 3'b100
    } sleep_state_t;

endpackage

// ---- hdl/ext_line_sense.sv ----
// External interrupt line sampler with edge and level detection.
// Assumes the pin is asynchronous to mclk; idle level is high.
`timescale 1ns/1ps
module ext_line_sense (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pin,
    input wire logic [1:0] sense_sel,
    output logic edge_event,
    output logic level_req
);
    logic sync1_reg; // First synchroniser stage
    logic sync2_reg; // Second synchroniser stage
    logic prev_reg; // Previous clean sample

    // ==========================================================
    // Two-stage synchroniser and previous sample
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            sync1_reg <= pin;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // ==========================================================
    // Decode of the sense select on sampled values
    always_comb begin
        edge_event = 1'b0;
        level_req = 1'b0;
        unique case (sense_sel)
            irq_ctrl_pkg::SENSE_LOW: level_req = ~sync2_reg;
            irq_ctrl_pkg::SENSE_RSVD: edge_event = 1'b0;
            irq_ctrl_pkg::SENSE_FALL: edge_event = prev_reg & ~sync2_reg;
            irq_ctrl_pkg::SENSE_RISE: edge_event = ~prev_reg & sync2_reg;
        endcase
    end
endmodule

// ---- hdl/reset_pin_filter.sv ----
// Reset pin filter: resets only after a low held for the least reset time.
// Assumes the active-low pin is asynchronous to mclk.
`timescale 1ns/1ps
module reset_pin_filter (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reset_pin_n,
    output logic pin_reset
);
    logic sync1_reg; // First synchroniser stage
    logic sync2_reg; // Second synchroniser stage
    logic [2:0] low_cnt_reg; // Consecutive low samples

    // ==========================================================
    // Synchroniser
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= reset_pin_n;
            sync2_reg <= sync1_reg;
        end
    end

    // ==========================================================
    // Low-time counter; shorter pulses fall through
    always_ff @(posedge mclk) begin
        if (rst) begin
            low_cnt_reg <= 3'h0;
            pin_reset <= 1'b0;
        end else if (!sync2_reg) begin
            if (low_cnt_reg != irq_ctrl_pkg::RST_MIN_CYC) begin
                low_cnt_reg <= low_cnt_reg + 3'h1;
            end
            pin_reset <= (low_cnt_reg >= irq_ctrl_pkg::RST_MIN_CYC - 3'h1);
        end else begin
            low_cnt_reg <= 3'h0;
            pin_reset <= 1'b0;
        end
    end
endmodule

// ---- testbench/timer_cpu_model.sv ----
// Model of the CPU core and timers beside the interrupt block.
// Assumes the block acknowledges a timer flag with a one-cycle pulse.
`timescale 1ns/1ps
module timer_cpu_model (
    input wire logic mclk,
    input wire logic rst,
    input wire irq_ctrl_pkg::timer_flags_t raise,
    input wire irq_ctrl_pkg::timer_flags_t timer_ack,
    output irq_ctrl_pkg::timer_flags_t timer_flags,
    output logic cpu_boundary
);
    // ==========================================================
    // Timer flags hold until the block acknowledges them
    always_ff @(posedge mclk) begin
        if (rst) begin
            timer_flags <= '0;
        end else begin
            timer_flags <= (timer_flags & ~timer_ack) | raise;
        end
    end
    // Every cycle ends an instruction in this core
    assign cpu_boundary = 1'b1;
endmodule

// ---- testbench/mcu_interrupt_control_tb_top.sv ----
// Testbench for the interrupt block: register calls and entry checks.
// Assumes the timer and CPU model in timer_cpu_model.sv.
`timescale 1ns/1ps
module mcu_interrupt_control_tb_top;
    logic mclk = 1'b0; // System clock
    logic rst = 1'b1; // Synchronous reset
    logic rpin_n = 1'b1; // Reset pin, active low
    logic line_a = 1'b1; // External line a
    logic line_b = 1'b1; // External line b
    logic gie = 1'b0; // Global enable
    logic sleep_cmd = 1'b0; // Sleep pulse
    logic [9:0] pc = 10'h155; // Return address offered
    irq_ctrl_pkg::io_req_t io_req = '0;
    irq_ctrl_pkg::timer_flags_t raise = '0;
    irq_ctrl_pkg::timer_flags_t tflags, tack;
    irq_ctrl_pkg::irq_entry_t irq_entry;
    logic [7:0] io_rdata;
    logic bnd, irq_enter, cpu_halt, osc_stop, port_tristate, sys_reset;
    int n_fail = 0;
    int check_count = 0;
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    irq_control u_irq_control (.mclk(mclk), .rst(rst), .reset_pin_n(rpin_n),
        .ext_irq_line_a(line_a), .ext_irq_line_b(line_b), .io_req(io_req),
        .global_irq_enable(gie), .cpu_boundary(bnd), .program_counter(pc),
        .timer_flags(tflags), .sleep_cmd(sleep_cmd), .io_rdata(io_rdata),
        .irq_enter(irq_enter), .irq_entry(irq_entry), .timer_ack(tack),
        .cpu_halt(cpu_halt), .osc_stop(osc_stop), .port_tristate(port_tristate),
        .sys_reset(sys_reset));
    timer_cpu_model u_timer_cpu_model (.mclk(mclk), .rst(rst), .raise(raise),
        .timer_ack(tack), .timer_flags(tflags), .cpu_boundary(bnd));
    // ==========================================================
    // Compare one value and count it
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge mclk);
        io_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge mclk);
        io_req = '0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(negedge mclk);
        io_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge mclk);
        io_req = '0;
        @(negedge mclk);
        check(io_rdata, exp);
    endtask
    // Wait for one entry under a bound, then check where it jumps
    task automatic take(input logic [9:0] vec);
        int n;
        n = 0;
        while (irq_enter !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        check(irq_enter, 1'b1);
        check(irq_entry.vector, vec);
        check(irq_entry.ret_pc, pc);
        @(negedge mclk);
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Watchdog well beyond the expected run
    initial begin
        #20000;
        n_fail++;
        stop_test();
    end
    // Main sequence
    initial begin
        repeat (6) @(negedge mclk);
        check(port_tristate, 1'b1);
        rst = 1'b0;
        rd(irq_ctrl_pkg::TIMER_MASK_ADDR, 8'h00);
        wr(irq_ctrl_pkg::TIMER_MASK_ADDR, 8'hFF);
        rd(irq_ctrl_pkg::TIMER_MASK_ADDR, 8'hCA);
        rd(6'h3F, 8'h00);
        wr(irq_ctrl_pkg::SENSE_CTRL_ADDR, 8'h0A);
        wr(irq_ctrl_pkg::GEN_MASK_ADDR, 8'hC0);
        line_a = 1'b0;
        repeat (4) @(negedge mclk);
        rd(irq_ctrl_pkg::EXT_FLAG_ADDR, 8'h40);
        wr(irq_ctrl_pkg::EXT_FLAG_ADDR, 8'h80);
        rd(irq_ctrl_pkg::EXT_FLAG_ADDR, 8'h40);
        wr(irq_ctrl_pkg::EXT_FLAG_ADDR, 8'h40);
        rd(irq_ctrl_pkg::EXT_FLAG_ADDR, 8'h00);
        line_a = 1'b1;
        repeat (4) @(negedge mclk);
        line_a = 1'b0;
        line_b = 1'b0;
        repeat (4) @(negedge mclk);
        rd(irq_ctrl_pkg::EXT_FLAG_ADDR, 8'hC0);
        check(irq_enter, 1'b0);
        gie = 1'b1;
        take(irq_ctrl_pkg::VEC_EXT_A);
        take(irq_ctrl_pkg::VEC_EXT_B);
        rd(irq_ctrl_pkg::EXT_FLAG_ADDR, 8'h00);
        $display("edge tests done");
        gie = 1'b0;
        wr(irq_ctrl_pkg::SENSE_CTRL_ADDR, 8'h05);
        line_a = 1'b1;
        line_b = 1'b1;
        repeat (4) @(negedge mclk);
        line_a = 1'b0;
        line_b = 1'b0;
        repeat (4) @(negedge mclk);
        rd(irq_ctrl_pkg::EXT_FLAG_ADDR, 8'h00);
        wr(irq_ctrl_pkg::SENSE_CTRL_ADDR, 8'h0F);
        line_a = 1'b1;
        line_b = 1'b1;
        repeat (4) @(negedge mclk);
        rd(irq_ctrl_pkg::EXT_FLAG_ADDR, 8'hC0);
        wr(irq_ctrl_pkg::EXT_FLAG_ADDR, 8'hC0);
        wr(irq_ctrl_pkg::SENSE_CTRL_ADDR, 8'h00);
        line_a = 1'b0;
        repeat (4) @(negedge mclk);
        rd(irq_ctrl_pkg::EXT_FLAG_ADDR, 8'h00);
        gie = 1'b1;
        take(irq_ctrl_pkg::VEC_EXT_A);
        gie = 1'b0;
        line_a = 1'b1;
        repeat (6) @(negedge mclk);
        $display("sense tests done");
        gie = 1'b1;
        raise = irq_ctrl_pkg::timer_flags_t'(4'hC);
        @(negedge mclk);
        raise = '0;
        take(irq_ctrl_pkg::VEC_T1_COMP);
        take(irq_ctrl_pkg::VEC_T1_OVF);
        sleep_cmd = 1'b1;
        @(negedge mclk);
        sleep_cmd = 1'b0;
        @(negedge mclk);
        check({osc_stop, cpu_halt}, 10'h001);
        raise = irq_ctrl_pkg::timer_flags_t'(4'h1);
        @(negedge mclk);
        raise = '0;
        take(irq_ctrl_pkg::VEC_T0_OVF);
        // Power-down with falling-edge lines; line a wakes the core
        wr(irq_ctrl_pkg::SENSE_CTRL_ADDR, 8'h1A);
        sleep_cmd = 1'b1;
        @(negedge mclk);
        sleep_cmd = 1'b0;
        @(negedge mclk);
        check({osc_stop, cpu_halt}, 10'h003);
        line_a = 1'b0;
        take(irq_ctrl_pkg::VEC_EXT_A);
        check(osc_stop, 1'b0);
        rpin_n = 1'b0;
        repeat (6) @(negedge mclk);
        check({sys_reset, port_tristate}, 10'h003);
        rpin_n = 1'b1;
        repeat (6) @(negedge mclk);
        rd(irq_ctrl_pkg::TIMER_MASK_ADDR, 8'h00);
        $display("timer and reset tests done");
        stop_test();
    end
endmodule
